// >>> level_pkg.sv
// constants, register map and packed carriers for the signal-level block
// assumes a 50 MHz system clock and a modem that strobes one pulse per bit
//
// Summary of operation
// - level measured after channel filter only
// - latched level captured once per packet
// - latch on preamble, sync or bit count
// - current level per bit or four-bit average
// - averaging postpones latch to seven bits
// - latched value cleared on receive entry
// - cleared but unlatched value reads zero
// - dBm equals half value minus offset minus 70
// - fast response registers return latched level
// - status query answers after 33 us
// - level above threshold flags the host
// - latched and live threshold routable to GPIO
// - rising and falling jumps enabled separately
// - jump is difference across span reaching threshold
// - optional receive restart on jump
// - jump reported by flag or GPIO
// - half decibel per count
package level_pkg;
    // =========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_LATCH    = 8'h04;
    localparam logic [7:0] OFS_THRESH   = 8'h08;
    localparam logic [7:0] OFS_JUMP     = 8'h0c;
    localparam logic [7:0] OFS_COMP     = 8'h10;
    localparam logic [7:0] OFS_FRR_CFG  = 8'h14;
    localparam logic [7:0] OFS_FRR0     = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h28;
    localparam logic [7:0] OFS_FLAGS    = 8'h2c;
    localparam logic [7:0] OFS_GPIO_SEL = 8'h30;
    localparam logic [7:0] OFS_DBM      = 8'h34;
    // =========================================================
    // reset values and limits
    localparam logic [7:0] COMP_RESET   = 8'h40;
    localparam logic [7:0] LATCH_RESET  = 8'h04;
    localparam logic [7:0] MIN_BITS     = 8'h04;
    localparam logic [7:0] MIN_BITS_AVG = 8'h07;
    localparam logic [7:0] DBM_FLOOR    = 8'h46;
    localparam int         AVG_SHIFT    = 2;
    // =========================================================
    // timing
    localparam int CLK_MHZ    = 50;
    localparam int CTS_NS     = 33000;
    localparam int CTS_CYCLES = (CTS_NS * CLK_MHZ + 999) / 1000;
    // =========================================================
    // field layout of the control word
    typedef enum logic [1:0] {
        LATCH_OFF      = 2'b00,
        LATCH_PREAMBLE = 2'b01,
        LATCH_SYNC     = 2'b10,
        LATCH_BITS     = 2'b11
    } latch_mode_t;

    typedef struct packed {
        logic        restart_en;
        logic        jump_dn_en;
        logic        jump_up_en;
        logic        avg4;
        latch_mode_t mode;
    } ctrl_t;
    localparam int CTRL_W = 6;

    // modem-side strobes, all in the system clock domain
    typedef struct packed {
        logic       rx_enter;
        logic       bit_tick;
        logic       preamble;
        logic       sync;
        logic [7:0] level;
    } modem_t;

    // source selects for fast response registers and gpio
    localparam logic [1:0] SEL_A = 2'b01;
    localparam logic [1:0] SEL_B = 2'b10;
    localparam logic [1:0] SEL_C = 2'b11;

    // =========================================================
    // shared arithmetic and field decode
    // saturating subtract
    function automatic logic [7:0] sat_sub(input logic [9:0] a, input logic [9:0] b);
        logic [9:0] d;
        d = a - b;
        sat_sub = (a < b) ? 8'h00 : ((d > 10'h0ff) ? 8'hff : d[7:0]);
    endfunction : sat_sub

    function automatic logic [1:0] field2(input logic [7:0] w, input logic [1:0] idx);
        field2 = w[{idx, 1'b0} +: 2];
    endfunction : field2
endpackage : level_pkg

// >>> signal_level.sv
// signal-level measurement, packet latch, threshold and jump detection
// assumes an ahb-lite master on i_clock and modem strobes on the same clock
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module signal_level
    import level_pkg::*;
#(
    parameter int HIST_DEPTH = 16
)
(
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // ahb-lite slave
    input  wire logic         i_hsel,
    input  wire logic [7:0]   i_haddr,
    input  wire logic [1:0]   i_htrans,
    input  wire logic         i_hwrite,
    input  wire logic [2:0]   i_hsize,
    input  wire logic         i_hready,
    input  wire logic [31:0]  i_hwdata,
    output logic [31:0]       o_hrdata,
    output logic              o_hreadyout,
    output logic              o_hresp,
    // modem side
    input  wire modem_t       i_modem,
    // status toward the receive machine and pins
    output logic              o_rx_restart,
    output logic [3:0]        o_gpio,
    output logic [7:0]        o_current,
    output logic [7:0]        o_latched
);
    if (HIST_DEPTH < 2 || HIST_DEPTH > 16)
        $error("HIST_DEPTH must be 2..16");
    // =========================================================
    // software-visible state
    ctrl_t       ctrl_ff;
    logic [7:0]  latch_bits_ff;
    logic [7:0]  thresh_ff;
    logic [7:0]  jump_thr_ff;
    logic [3:0]  jump_span_ff;
    logic [7:0]  comp_ff;
    logic [7:0]  frr_cfg_ff;
    logic [7:0]  gpio_sel_ff;
    logic        flag_thr_ff;
    logic        flag_jump_ff;
    logic        cts_ff;
    logic [10:0] cts_cnt_ff;
    logic [7:0]  snap_cur_ff;
    logic [7:0]  snap_lat_ff;

    // =========================================================
    // ahb-lite slave: one wait state, registered read data
    logic        pend_ff;
    logic        pend_wr_ff;
    logic [7:0]  pend_addr_ff;
    logic        hready_ff;
    logic [31:0] hrdata_ff;
    wire         addr_phase = i_hsel && i_hready && i_htrans[1];
    wire         do_write   = pend_ff && pend_wr_ff;
    wire         do_read    = pend_ff && !pend_wr_ff;
    wire         wr_ctrl    = do_write && pend_addr_ff == OFS_CTRL;
    wire         wr_latch   = do_write && pend_addr_ff == OFS_LATCH;
    wire         wr_thresh  = do_write && pend_addr_ff == OFS_THRESH;
    wire         wr_jump    = do_write && pend_addr_ff == OFS_JUMP;
    wire         wr_comp    = do_write && pend_addr_ff == OFS_COMP;
    wire         wr_frr     = do_write && pend_addr_ff == OFS_FRR_CFG;
    wire         wr_status  = do_write && pend_addr_ff == OFS_STATUS;
    wire         wr_flags   = do_write && pend_addr_ff == OFS_FLAGS;
    wire         wr_gpio    = do_write && pend_addr_ff == OFS_GPIO_SEL;
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            pend_ff      <= 1'b0;
            pend_wr_ff   <= 1'b0;
            pend_addr_ff <= 8'h00;
            hready_ff    <= 1'b1;
        end
        else
        begin
            pend_ff      <= addr_phase;
            pend_wr_ff   <= i_hwrite;
            pend_addr_ff <= addr_phase ? {i_haddr[7:2], 2'b00} : pend_addr_ff;
            hready_ff    <= !addr_phase;
        end
    end

    // =========================================================
    // current level, per bit or averaged over four bits
    logic [7:0]  cur_ff;
    logic [9:0]  acc_ff;
    logic [1:0]  phase_ff;
    logic        upd_ff;
    wire  [9:0]  acc_sum   = acc_ff + {2'b00, i_modem.level};
    wire         avg_done  = i_modem.bit_tick && phase_ff == 2'b11;
    wire         cur_upd   = i_modem.bit_tick && (!ctrl_ff.avg4 || avg_done);
    wire  [7:0]  nxt_cur   = ctrl_ff.avg4 ? acc_sum[AVG_SHIFT +: 8] : i_modem.level;
    always_ff @(posedge i_clock)
    begin
        if (i_rst || i_modem.rx_enter)
        begin
            cur_ff   <= 8'h00;
            acc_ff   <= 10'h000;
            phase_ff <= 2'b00;
            upd_ff   <= 1'b0;
        end
        else
        begin
            // level comes from the filtered in-band power
            cur_ff   <= cur_upd ? nxt_cur : cur_ff;
            acc_ff   <= i_modem.bit_tick ? (avg_done ? 10'h000 : acc_sum) : acc_ff;
            phase_ff <= i_modem.bit_tick ? phase_ff + 2'b01 : phase_ff;
            upd_ff   <= cur_upd;
        end
    end

    // =========================================================
    // packet latch
    logic [7:0]  bitcnt_ff;
    logic [7:0]  lat_ff;
    logic        seen_ff;
    logic        done_ff;
    wire  [7:0]  min_bits  = ctrl_ff.avg4 ? MIN_BITS_AVG : MIN_BITS;
    wire  [7:0]  want_bits = (ctrl_ff.mode == LATCH_BITS && latch_bits_ff > min_bits) ? latch_bits_ff : min_bits;
    wire         ev_now    = (ctrl_ff.mode == LATCH_PREAMBLE && i_modem.preamble)
                          || (ctrl_ff.mode == LATCH_SYNC && i_modem.sync)
                          || ctrl_ff.mode == LATCH_BITS;
    // never before the minimum bit count
    wire         do_latch  = !done_ff && (seen_ff || ev_now) && bitcnt_ff >= want_bits;
    always_ff @(posedge i_clock)
    begin
        if (i_rst || i_modem.rx_enter)
        begin
            bitcnt_ff <= 8'h00;
            lat_ff    <= 8'h00;
            seen_ff   <= 1'b0;
            done_ff   <= 1'b0;
        end
        else
        begin
            bitcnt_ff <= (i_modem.bit_tick && bitcnt_ff != 8'hff) ? bitcnt_ff + 8'h01 : bitcnt_ff;
            seen_ff   <= seen_ff || (ev_now && ctrl_ff.mode != LATCH_OFF);
            lat_ff    <= do_latch ? cur_ff : lat_ff;
            done_ff   <= done_ff || do_latch;
        end
    end

    // =========================================================
    // threshold and jump detection
    logic [7:0]  hist_ff [HIST_DEPTH];
    logic [4:0]  fill_ff;
    logic        above_ff;
    wire  [7:0]  old_lvl   = hist_ff[jump_span_ff];
    wire  [7:0]  rise      = sat_sub({2'b00, cur_ff}, {2'b00, old_lvl});
    wire  [7:0]  fall      = sat_sub({2'b00, old_lvl}, {2'b00, cur_ff});
    wire         span_ok   = fill_ff > {1'b0, jump_span_ff};
    // each polarity on its own enable
    wire         jump_hit  = upd_ff && span_ok && jump_thr_ff != 8'h00
                          && ((ctrl_ff.jump_up_en && rise >= jump_thr_ff)
                          ||  (ctrl_ff.jump_dn_en && fall >= jump_thr_ff));
    wire         above     = cur_ff > thresh_ff;
    wire         thr_set   = upd_ff && above;
    always_ff @(posedge i_clock)
    begin
        if (i_rst || i_modem.rx_enter)
            fill_ff <= 5'h00;
        else if (upd_ff && fill_ff != 5'h1f)
            fill_ff <= fill_ff + 5'h01;
    end
    always_ff @(posedge i_clock)
    begin
        if (upd_ff)
        begin
            hist_ff[0] <= cur_ff;
            for (int i = 1; i < HIST_DEPTH; i++)
                hist_ff[i] <= hist_ff[i - 1];
        end
    end

    // =========================================================
    // flags, restart and pins
    logic        restart_ff;
    logic [3:0]  gpio_ff;
    logic [3:0]  nxt_gpio;
    always_comb
    begin
        nxt_gpio = 4'h0;
        for (int g = 0; g < 4; g++)
        begin
            // live and latched threshold on any pin
            case (field2(gpio_sel_ff, 2'(g)))
                SEL_A:   nxt_gpio[g] = above;
                SEL_B:   nxt_gpio[g] = flag_thr_ff;
                SEL_C:   nxt_gpio[g] = flag_jump_ff;
                default: nxt_gpio[g] = 1'b0;
            endcase
        end
    end
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            flag_thr_ff  <= 1'b0;
            flag_jump_ff <= 1'b0;
            above_ff     <= 1'b0;
            restart_ff   <= 1'b0;
            gpio_ff      <= 4'h0;
        end
        else
        begin
            // set wins over a write-one clear
            flag_thr_ff  <= thr_set || (flag_thr_ff && !(wr_flags && i_hwdata[0]));
            flag_jump_ff <= jump_hit || (flag_jump_ff && !(wr_flags && i_hwdata[1]));
            above_ff     <= above;
            restart_ff   <= jump_hit && ctrl_ff.restart_en;
            gpio_ff      <= nxt_gpio;
        end
    end

    // =========================================================
    // configuration registers
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            ctrl_ff       <= '0;
            latch_bits_ff <= LATCH_RESET;
            thresh_ff     <= 8'hff;
            jump_thr_ff   <= 8'h00;
            jump_span_ff  <= 4'h1;
            comp_ff       <= COMP_RESET;
            frr_cfg_ff    <= 8'h00;
            gpio_sel_ff   <= 8'h00;
        end
        else
        begin
            ctrl_ff       <= wr_ctrl ? ctrl_t'(i_hwdata[CTRL_W-1:0]) : ctrl_ff;
            latch_bits_ff <= wr_latch ? i_hwdata[7:0] : latch_bits_ff;
            thresh_ff     <= wr_thresh ? i_hwdata[7:0] : thresh_ff;
            jump_thr_ff   <= wr_jump ? i_hwdata[7:0] : jump_thr_ff;
            jump_span_ff  <= (wr_jump && {1'b0, i_hwdata[11:8]} < 5'(HIST_DEPTH)) ? i_hwdata[11:8] : jump_span_ff;
            comp_ff       <= wr_comp ? i_hwdata[7:0] : comp_ff;
            frr_cfg_ff    <= wr_frr ? i_hwdata[7:0] : frr_cfg_ff;
            gpio_sel_ff   <= wr_gpio ? i_hwdata[7:0] : gpio_sel_ff;
        end
    end

    // =========================================================
    // status query: snapshot now, clear-to-send after the delay
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            cts_ff      <= 1'b1;
            cts_cnt_ff  <= 11'h000;
            snap_cur_ff <= 8'h00;
            snap_lat_ff <= 8'h00;
        end
        else if (wr_status)
        begin
            cts_ff      <= 1'b0;
            cts_cnt_ff  <= 11'(CTS_CYCLES - 1);
            snap_cur_ff <= cur_ff;
            snap_lat_ff <= lat_ff;
        end
        else
        begin
            cts_ff      <= cts_ff || cts_cnt_ff == 11'h000;
            cts_cnt_ff  <= (cts_cnt_ff != 11'h000) ? cts_cnt_ff - 11'h001 : cts_cnt_ff;
        end
    end

    // =========================================================
    // read mux
    // dBm = value/2 - offset - 70, floored at zero magnitude
    wire  [7:0]  dbm_mag  = sat_sub({2'b00, comp_ff} + {2'b00, DBM_FLOOR}, {3'b000, cur_ff[7:1]});
    wire  [1:0]  frr_idx  = pend_addr_ff[3:2] - OFS_FRR0[3:2];
    wire  [1:0]  frr_src  = field2(frr_cfg_ff, frr_idx);
    wire         is_frr   = pend_addr_ff >= OFS_FRR0 && pend_addr_ff < OFS_STATUS;
    wire  [7:0]  frr_val  = (frr_src == SEL_A) ? cur_ff
                          : (frr_src == SEL_B) ? lat_ff
                          : (frr_src == SEL_C) ? {6'h00, flag_jump_ff, flag_thr_ff} : 8'h00;
    logic [31:0] rd_val;
    always_comb
    begin
        case (pend_addr_ff)
            OFS_CTRL:     rd_val = {26'h0, ctrl_ff};
            OFS_LATCH:    rd_val = {24'h0, latch_bits_ff};
            OFS_THRESH:   rd_val = {24'h0, thresh_ff};
            OFS_JUMP:     rd_val = {20'h0, jump_span_ff, jump_thr_ff};
            OFS_COMP:     rd_val = {24'h0, comp_ff};
            OFS_FRR_CFG:  rd_val = {24'h0, frr_cfg_ff};
            OFS_STATUS:   rd_val = cts_ff ? {8'h0, snap_lat_ff, snap_cur_ff, 7'h0, cts_ff} : 32'h0;
            OFS_FLAGS:    rd_val = {29'h0, above_ff, flag_jump_ff, flag_thr_ff};
            OFS_GPIO_SEL: rd_val = {24'h0, gpio_sel_ff};
            OFS_DBM:      rd_val = {24'h0, dbm_mag};
            default:      rd_val = is_frr ? {24'h0, frr_val} : 32'h0;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            hrdata_ff <= 32'h0;
        else if (do_read)
            hrdata_ff <= rd_val;
    end
    assign o_hrdata     = hrdata_ff;
    assign o_hreadyout  = hready_ff;
    assign o_hresp      = 1'b0;
    assign o_rx_restart = restart_ff;
    assign o_gpio       = gpio_ff;
    assign o_current    = cur_ff;
    assign o_latched    = lat_ff;

    // =========================================================
    // checks
    // cycles waited since the query
    logic [10:0] cts_age_ff;
    always_ff @(posedge i_clock)
        cts_age_ff <= (i_rst || wr_status) ? 11'h000 : cts_age_ff + {10'h000, !cts_ff && cts_age_ff != 11'h7ff};
    a_latch_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        i_modem.rx_enter |=> lat_ff == 8'h00 && !done_ff) else $error("latched level not cleared on receive entry");
    a_latch_min: assert property (@(posedge i_clock) disable iff (i_rst)
        do_latch |-> bitcnt_ff >= (ctrl_ff.avg4 ? MIN_BITS_AVG : MIN_BITS)) else $error("latch too early");
    a_latch_once: assert property (@(posedge i_clock) disable iff (i_rst || i_modem.rx_enter)
        done_ff |=> lat_ff == $past(lat_ff)) else $error("latched level changed twice in a packet");
    a_avg_cadence: assert property (@(posedge i_clock) disable iff (i_rst)
        (cur_upd && ctrl_ff.avg4) |-> phase_ff == 2'b11) else $error("averaged level refreshed off the fourth bit");
    a_cts_delay: assert property (@(posedge i_clock) disable iff (i_rst)
        (!cts_ff || $rose(cts_ff)) |-> cts_ff == (cts_age_ff == 11'(CTS_CYCLES)) && cts_age_ff <= 11'(CTS_CYCLES))
        else $error("clear-to-send timing wrong");
    a_thr_flag: assert property (@(posedge i_clock) disable iff (i_rst)
        thr_set |=> flag_thr_ff) else $error("threshold flag missed");
    a_restart: assert property (@(posedge i_clock) disable iff (i_rst)
        (jump_hit && ctrl_ff.restart_en) |=> o_rx_restart ##1 (!o_rx_restart || $past(jump_hit && ctrl_ff.restart_en)))
        else $error("restart pulse wrong");
    a_jump_polar: assert property (@(posedge i_clock) disable iff (i_rst)
        jump_hit |-> (ctrl_ff.jump_up_en && rise >= jump_thr_ff) || (ctrl_ff.jump_dn_en && fall >= jump_thr_ff));
    a_jump_flag: assert property (@(posedge i_clock) disable iff (i_rst)
        jump_hit |=> flag_jump_ff) else $error("jump flag missed");
    c_latch_avg:  cover property (@(posedge i_clock) do_latch && ctrl_ff.avg4);
    c_jump_rst:   cover property (@(posedge i_clock) jump_hit && ctrl_ff.restart_en);
    c_status_cts: cover property (@(posedge i_clock) $rose(cts_ff) && cts_age_ff == 11'(CTS_CYCLES));
endmodule : signal_level

// >>> modem_strobe_model.sv
// behavioural modem: receive entry, bit strobes, preamble and sync pulses
// assumes calls start just after a rising edge of i_clock
`timescale 1ns/1ns
module modem_strobe_model
    import level_pkg::*;
(
    // clock
    input  wire logic i_clock,
    // strobes toward the level block
    output modem_t    o_modem
);
    initial o_modem = '0;

    // =========================================================
    // receive entry, always ahead of any bit strobe
    task enter();
        o_modem.rx_enter <= 1'b1;
        @(posedge i_clock);
        o_modem.rx_enter <= 1'b0;
        repeat (2) @(posedge i_clock);
    endtask : enter

    // =========================================================
    // n bits, level ramps by step; gaps let the block settle
    task bits(input int n, input logic [7:0] lvl, input logic [7:0] step, input int pre_at, input int sync_at);
        for (int i = 0; i < n; i++)
        begin
            o_modem.level    <= lvl + 8'(i) * step;
            o_modem.bit_tick <= 1'b1;
            o_modem.preamble <= (i == pre_at);
            o_modem.sync     <= (i == sync_at);
            @(posedge i_clock);
            o_modem.bit_tick <= 1'b0;
            o_modem.preamble <= 1'b0;
            o_modem.sync     <= 1'b0;
            repeat (3) @(posedge i_clock);
        end
    endtask : bits
endmodule : modem_strobe_model

// >>> signal_level_tb.sv
// self-checking bench for the signal-level block over ahb-lite
// assumes one slave on the bus, so hready is the slave's hreadyout
`timescale 1ns/1ns
module signal_level_tb
    import level_pkg::*;
;
    logic        i_clock;
    logic        i_rst;
    logic        hsel;
    logic        hwrite;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        rx_restart;
    logic [3:0]  gpio;
    logic [7:0]  cur;
    logic [7:0]  lat;
    modem_t      modem;
    logic [31:0] rd;
    logic [7:0]  lv;
    int          err_total;
    int          cmp_count;
    int          restarts;
    int          cyc;
    int          t0;
    int          r0;

    signal_level i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout), .i_hwdata(hwdata), .o_hrdata(hrdata),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .i_modem(modem), .o_rx_restart(rx_restart), .o_gpio(gpio),
        .o_current(cur), .o_latched(lat));
    modem_strobe_model i_mdm (.i_clock(i_clock), .o_modem(modem));

    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        if (rx_restart === 1'b1)
            restarts <= restarts + 1;
    end

    // =========================================================
    // bus and compare helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        @(posedge i_clock);
        while (hreadyout !== 1'b1)
            @(posedge i_clock);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge i_clock);
        while (hreadyout !== 1'b1)
            @(posedge i_clock);
        rd = hrdata;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk

    task stop_test();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // hang guard, generous against roughly 2k cycles of tests
    initial
    begin
        #400000;
        err_total++;
        stop_test();
    end

    // =========================================================
    // test sequence
    initial
    begin
        {hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'b010;
        {err_total, cmp_count, restarts, cyc} = '0;
        i_rst = 1'b1;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rchk(OFS_COMP, 32'h40);
        rchk(OFS_THRESH, 32'hff);
        rchk(OFS_LATCH, 32'h04);
        rchk(8'h3c, 32'h0);
        check({24'h0, lat}, 32'h0);
        $display("reset test done");
        for (int m = 0; m < 4; m++)
        begin
            lv = 8'h50 + 8'(m);
            wr(OFS_CTRL, 32'(m));
            i_mdm.enter();
            check({24'h0, lat}, 32'h0);
            i_mdm.bits(1, lv, 8'h0, -1, -1);
            check({24'h0, cur}, {24'h0, lv});
            i_mdm.bits(3, lv, 8'h0, -1, -1);
            check({24'h0, lat}, (m == 3) ? {24'h0, lv} : 32'h0);
            i_mdm.bits(2, lv, 8'h0, (m == 1) ? 0 : -1, (m == 2) ? 0 : -1);
            check({24'h0, lat}, (m == 0) ? 32'h0 : {24'h0, lv});
            i_mdm.bits(2, 8'h20, 8'h0, 0, 0);
            check({24'h0, lat}, (m == 0) ? 32'h0 : {24'h0, lv});
        end
        repeat (20) @(posedge i_clock);
        check({24'h0, lat}, 32'h53);
        wr(OFS_FRR_CFG, 32'h06);
        // no clear-to-send poll before the fast reads
        rchk(OFS_FRR0, 32'h53);
        rchk(OFS_FRR0 + 8'h04, 32'h20);
        rchk(OFS_DBM, 32'h76);
        wr(OFS_COMP, 32'hff);
        rchk(OFS_DBM, 32'hff);
        wr(OFS_COMP, 32'h40);
        $display("latch and readout test done");
        wr(OFS_STATUS, 32'h0);
        t0 = cyc;
        rchk(OFS_STATUS, 32'h0);
        for (int n = 0; n < 1000 && rd[0] !== 1'b1; n++)
            xfer(1'b0, OFS_STATUS, 32'h0);
        check(32'(cyc - t0 >= CTS_CYCLES - 2 && cyc - t0 <= CTS_CYCLES + 5), 32'h1);
        check(rd, 32'h00532001);
        $display("status query test done");
        wr(OFS_CTRL, 32'h07);
        i_mdm.enter();
        i_mdm.bits(3, 8'h10, 8'h10, -1, -1);
        check({24'h0, cur}, 32'h0);
        i_mdm.bits(1, 8'h40, 8'h0, -1, -1);
        check({24'h0, cur}, 32'h28);
        i_mdm.bits(2, 8'h28, 8'h0, -1, -1);
        check({24'h0, lat}, 32'h0);
        i_mdm.bits(1, 8'h28, 8'h0, -1, -1);
        check({24'h0, lat}, 32'h28);
        $display("averaging test done");
        wr(OFS_CTRL, 32'h03);
        wr(OFS_THRESH, 32'h30);
        wr(OFS_GPIO_SEL, 32'h39);
        i_mdm.enter();
        i_mdm.bits(4, 8'h30, 8'h0, -1, -1);
        check({30'h0, gpio[1:0]}, 32'h0);
        i_mdm.bits(1, 8'h31, 8'h0, -1, -1);
        check({30'h0, gpio[1:0]}, 32'h3);
        rchk(OFS_FLAGS, 32'h5);
        i_mdm.bits(1, 8'h30, 8'h0, -1, -1);
        check({30'h0, gpio[1:0]}, 32'h2);
        wr(OFS_FLAGS, 32'h1);
        @(posedge i_clock);
        check({30'h0, gpio[1:0]}, 32'h0);
        $display("threshold test done");
        wr(OFS_THRESH, 32'hff);
        wr(OFS_JUMP, 32'h10);
        wr(OFS_CTRL, 32'h0);
        i_mdm.enter();
        i_mdm.bits(4, 8'h20, 8'h0, -1, -1);
        // jump detect armed only mid-packet
        wr(OFS_CTRL, 32'h28);
        r0 = restarts;
        i_mdm.bits(1, 8'h28, 8'h0, -1, -1);
        check({31'h0, gpio[2]}, 32'h0);
        i_mdm.bits(1, 8'h38, 8'h0, -1, -1);
        check({31'h0, gpio[2]}, 32'h1);
        check(32'(restarts - r0), 32'h1);
        rchk(OFS_FLAGS, 32'h2);
        wr(OFS_FLAGS, 32'h2);
        i_mdm.bits(1, 8'h20, 8'h0, -1, -1);
        check({31'h0, gpio[2]}, 32'h0);
        wr(OFS_CTRL, 32'h10);
        r0 = restarts;
        i_mdm.bits(1, 8'h38, 8'h0, -1, -1);
        check({31'h0, gpio[2]}, 32'h0);
        i_mdm.bits(1, 8'h20, 8'h0, -1, -1);
        check({31'h0, gpio[2]}, 32'h1);
        check(32'(restarts - r0), 32'h0);
        $display("jump test done");
        stop_test();
    end
endmodule : signal_level_tb
